/* verilog/csb_pkg.sv */
// constants and carrier types for the card slot bridge controller
package csb_pkg;
  localparam int          ADDR_W            = 11;
  localparam int          DATA_W            = 16;
  localparam int          BYTE_W            = 8;
  localparam int          FLASH_WORD_W      = 10;
  localparam logic [10:0] CFG_OPT_ADDR      = 11'h200;
  localparam logic [10:0] CFG_STAT_ADDR     = 11'h202;
  localparam logic [10:0] PIN_REP_ADDR      = 11'h204;
  localparam int          OPT_SOFT_RST_BIT  = 7;
  localparam int          OPT_INDEX_W       = 6;
  localparam int          STAT_CHG_EN_BIT   = 4;
  localparam int          STAT_CHANGED_BIT  = 5;
  localparam int          PIN_READY_BIT     = 1;
  localparam int          PIN_CHANGED_BIT   = 5;
  localparam logic [7:0]  CFG_OPT_RESET     = 8'h00;
  localparam logic [7:0]  CFG_STAT_RESET    = 8'h00;
  localparam logic [7:0]  IO_REG_RESET      = 8'h00;
  localparam logic [1:0]  IO_ADDR_REG       = 2'h0;
  localparam logic [1:0]  IO_DATA_REG       = 2'h1;
  localparam logic [1:0]  IO_STATUS_REG     = 2'h2;
  localparam int          IO_STAT_HOST_BIT  = 0;
  localparam int          IO_STAT_PROC_BIT  = 1;

  typedef struct packed {
    logic [10:0] addr;
    logic        even_lane_select_n;
    logic        odd_lane_select_n;
    logic        space_select;
    logic        mem_read_strobe_n;
    logic        mem_write_strobe_n;
    logic        io_read_strobe_n;
    logic        io_write_strobe_n;
  } csb_host_ctl_t;

  typedef struct packed {
    logic [1:0] addr;
    logic       space_select_n;
    logic       read_strobe_n;
    logic       write_strobe_n;
  } csb_proc_ctl_t;

  typedef struct packed {
    logic en_even;
    logic en_odd;
    logic odd_on_even;
    logic byte_mode;
  } csb_lanes_t;
endpackage

/* verilog/csb_card_ctrl.sv */
// card-side slot controller: host decode, flash steering, shared i/o space
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
module csb_card_ctrl #(
  parameter int CIS_DEPTH = 16
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire csb_pkg::csb_host_ctl_t host_ctl,
  input  wire logic [15:0]           host_data_in,
  output logic [15:0]                host_data_out,
  output logic                       host_even_oe,
  output logic                       host_odd_oe,
  output logic                       io_read_ack_n,
  output logic                       ready_or_irq_out,
  output logic                       status_change_out_n,
  output logic                       cycle_extend_n,
  input  wire logic                  flash_ready_in_n,
  input  wire logic                  flash_wait_in_n,
  output logic                       flash_byte_mode_n,
  output logic [10:0]                flash_address,
  output logic                       flash_reset_out_n,
  output logic                       flash_read_strobe_n,
  output logic                       flash_chip_select_n,
  output logic                       flash_write_strobe_n,
  input  wire logic [15:0]           flash_data_in,
  output logic [15:0]                flash_data_out,
  output logic                       flash_data_oe,
  input  wire logic                  processor_clock,
  input  wire csb_pkg::csb_proc_ctl_t proc_ctl,
  input  wire logic [7:0]            proc_data_in,
  output logic [7:0]                 proc_data_out,
  output logic                       proc_data_oe
);
  // table must stay below the configuration registers at 0x200
  if (CIS_DEPTH < 2 || CIS_DEPTH > 256)
  begin : g_depth_check
    $error("CIS_DEPTH out of range");
  end

  // processor_clock only matters to the processor; all logic runs on ref_clk
  logic                 unused_clk;
  assign unused_clk = processor_clock;

  function automatic csb_pkg::csb_lanes_t lane_decode(input logic even_n, input logic odd_n, input logic a0);
    csb_pkg::csb_lanes_t l;
    l.en_even     = !even_n;
    l.en_odd      = !odd_n;
    l.odd_on_even = !even_n && odd_n && a0;
    l.byte_mode   = even_n != odd_n;
    return l;
  endfunction

  // sample of last cycle's strobes; edges come from these
  logic [4:0]           strobe_q;
  logic                 mem_wr_fall;
  logic                 io_wr_fall;
  logic                 io_rd_rise;
  logic                 io_rd_hold;
  logic                 proc_wr_fall;
  logic                 card_sel;
  logic                 io_mode;
  logic                 soft_rst;
  logic                 common_acc;
  logic                 attr_acc;
  logic                 io_acc;
  logic                 host_rd;
  logic                 ready_state;
  logic                 irq_pend;
  logic                 proc_pend;
  logic [7:0]           cfg_opt;
  logic [7:0]           cfg_stat;
  logic                 ready_q;
  logic [7:0]           io_addr_reg;
  logic [7:0]           io_data_reg;
  logic [7:0]           io_stat;
  logic [7:0]           wr_byte;
  logic [7:0]           attr_byte;
  logic [7:0]           io_byte;
  csb_pkg::csb_lanes_t  lanes;

  assign lanes    = lane_decode(host_ctl.even_lane_select_n, host_ctl.odd_lane_select_n, host_ctl.addr[0]);
  assign card_sel = lanes.en_even || lanes.en_odd;
  assign io_mode  = cfg_opt[csb_pkg::OPT_INDEX_W-1:0] != 6'h00;
  assign soft_rst = cfg_opt[csb_pkg::OPT_SOFT_RST_BIT];

  assign common_acc = card_sel && host_ctl.space_select && !io_mode;
  assign attr_acc   = card_sel && !host_ctl.space_select;
  assign io_acc     = card_sel && !host_ctl.space_select && io_mode
                      && !(host_ctl.io_read_strobe_n && host_ctl.io_write_strobe_n);
  assign host_rd    = !host_ctl.mem_read_strobe_n || (!host_ctl.io_read_strobe_n && io_mode);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      strobe_q <= 5'h1F;
    else
      strobe_q <= {host_ctl.mem_write_strobe_n, host_ctl.io_write_strobe_n, host_ctl.io_read_strobe_n,
                   proc_ctl.write_strobe_n, proc_ctl.read_strobe_n};
  end
  assign mem_wr_fall  = strobe_q[4] && !host_ctl.mem_write_strobe_n;
  assign io_wr_fall   = strobe_q[3] && !host_ctl.io_write_strobe_n && io_mode;
  assign io_rd_rise   = !strobe_q[2] && host_ctl.io_read_strobe_n && io_mode;
  assign proc_wr_fall = strobe_q[1] && !proc_ctl.write_strobe_n && !proc_ctl.space_select_n;

  // remembers the read target: a host may drop select and address with the strobe
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      io_rd_hold <= 1'b0;
    else
      io_rd_hold <= io_mode && attr_acc && !host_ctl.io_read_strobe_n
                    && host_ctl.addr[1:0] != csb_pkg::IO_STATUS_REG;
  end

  // byte written by the host: odd byte only when the odd lane alone is selected
  assign wr_byte = (lanes.en_odd && !lanes.en_even) ? host_data_in[15:8] : host_data_in[7:0];

  // configuration registers; soft reset bit only clears by host write
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_opt  <= csb_pkg::CFG_OPT_RESET;
      cfg_stat <= csb_pkg::CFG_STAT_RESET;
      ready_q  <= 1'b0;
    end
    else
    begin
      ready_q <= ready_state;
      if (mem_wr_fall && attr_acc && host_ctl.addr == csb_pkg::CFG_OPT_ADDR)
        cfg_opt <= wr_byte;
      if (mem_wr_fall && attr_acc && host_ctl.addr == csb_pkg::CFG_STAT_ADDR)
      begin
        cfg_stat <= wr_byte & ~(8'h01 << csb_pkg::STAT_CHANGED_BIT);
        if (!wr_byte[csb_pkg::STAT_CHANGED_BIT])
          cfg_stat[csb_pkg::STAT_CHANGED_BIT] <= cfg_stat[csb_pkg::STAT_CHANGED_BIT];
      end
      // set wins over a write-one clear in the same cycle
      if (ready_state != ready_q)
        cfg_stat[csb_pkg::STAT_CHANGED_BIT] <= 1'b1;
    end
  end

  assign ready_state = flash_ready_in_n && !soft_rst;

  // shared i/o registers: processor has priority on a same-cycle write
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      io_addr_reg <= csb_pkg::IO_REG_RESET;
      io_data_reg <= csb_pkg::IO_REG_RESET;
    end
    else if (proc_wr_fall)
    begin
      if (proc_ctl.addr == csb_pkg::IO_ADDR_REG)
        io_addr_reg <= proc_data_in;
      if (proc_ctl.addr == csb_pkg::IO_DATA_REG)
        io_data_reg <= proc_data_in;
    end
    else if (io_wr_fall && attr_acc)
    begin
      if (host_ctl.addr[1:0] == csb_pkg::IO_ADDR_REG)
        io_addr_reg <= wr_byte;
      if (host_ctl.addr[1:0] == csb_pkg::IO_DATA_REG)
        io_data_reg <= wr_byte;
    end
  end

  // pending flags; the setting event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_pend  <= 1'b0;
      proc_pend <= 1'b0;
    end
    else
    begin
      if (proc_wr_fall && proc_ctl.addr != csb_pkg::IO_STATUS_REG)
        irq_pend <= 1'b1;
      else if (io_rd_rise && io_rd_hold)
        irq_pend <= 1'b0;
      if (io_wr_fall && attr_acc && host_ctl.addr[1:0] != csb_pkg::IO_STATUS_REG)
        proc_pend <= 1'b1;
      else if (strobe_q[0] && !proc_ctl.read_strobe_n && !proc_ctl.space_select_n
               && proc_ctl.addr != csb_pkg::IO_STATUS_REG)
        proc_pend <= 1'b0;
    end
  end

  always_comb
  begin
    io_stat                             = 8'h00;
    io_stat[csb_pkg::IO_STAT_HOST_BIT]  = irq_pend;
    io_stat[csb_pkg::IO_STAT_PROC_BIT]  = proc_pend;
  end

  function automatic logic [7:0] io_select(input logic [1:0] a, input logic [7:0] ar, input logic [7:0] dr,
                                           input logic [7:0] sr);
    return (a == csb_pkg::IO_ADDR_REG) ? ar : (a == csb_pkg::IO_DATA_REG) ? dr :
           (a == csb_pkg::IO_STATUS_REG) ? sr : 8'h00;
  endfunction

  // read-only info table, even bytes only; writes into it are ignored
  function automatic logic [7:0] cis_byte(input logic [9:0] idx);
    unique case (idx[3:0])
      4'h0:    return 8'h01;
      4'h1:    return 8'h03;
      4'h2:    return 8'h53;
      4'h3:    return 8'hFF;
      default: return 8'hFF;
    endcase
  endfunction

  always_comb
  begin
    attr_byte = 8'h00;
    if (host_ctl.addr == csb_pkg::CFG_OPT_ADDR)
      attr_byte = cfg_opt;
    else if (host_ctl.addr == csb_pkg::CFG_STAT_ADDR)
      attr_byte = cfg_stat;
    else if (host_ctl.addr == csb_pkg::PIN_REP_ADDR)
    begin
      attr_byte[csb_pkg::PIN_READY_BIT]   = ready_state;
      attr_byte[csb_pkg::PIN_CHANGED_BIT] = cfg_stat[csb_pkg::STAT_CHANGED_BIT];
    end
    else if (host_ctl.addr < 11'(2 * CIS_DEPTH) && !host_ctl.addr[0])
      attr_byte = cis_byte(host_ctl.addr[10:1]);
  end

  assign io_byte = io_select(host_ctl.addr[1:0], io_addr_reg, io_data_reg, io_stat);

  // host read data registered each cycle of an attribute or common memory read, or of an i/o read in i/o mode
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      host_data_out <= 16'h0000;
    else if (!host_ctl.io_read_strobe_n && io_mode && attr_acc)
      host_data_out <= {io_byte, io_byte};
    else if (!host_ctl.mem_read_strobe_n && attr_acc)
      host_data_out <= {attr_byte, attr_byte};
    else if (!host_ctl.mem_read_strobe_n && common_acc)
    begin
      if (lanes.byte_mode)
        host_data_out <= {flash_data_in[7:0], flash_data_in[7:0]};
      else
        host_data_out <= flash_data_in;
    end
  end

  assign host_even_oe = card_sel && host_rd && lanes.en_even;
  assign host_odd_oe  = card_sel && host_rd && lanes.en_odd && !(io_mode && !host_ctl.io_read_strobe_n && lanes.en_even);

  assign io_read_ack_n = !(io_mode && attr_acc && !host_ctl.io_read_strobe_n);

  assign cycle_extend_n = !((io_acc && !proc_ctl.space_select_n) || (common_acc && !flash_wait_in_n));

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ready_or_irq_out    <= 1'b0;
      status_change_out_n <= 1'b1;
    end
    else
    begin
      if (io_mode)
        ready_or_irq_out <= !irq_pend;
      else
        ready_or_irq_out <= ready_state;
      status_change_out_n <= !(io_mode && cfg_stat[csb_pkg::STAT_CHG_EN_BIT]
                               && cfg_stat[csb_pkg::STAT_CHANGED_BIT]);
    end
  end

  // flash side: address, controls and flash strobes all registered together, changing on the same ref_clk edge
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      flash_address        <= 11'h000;
      flash_byte_mode_n    <= 1'b1;
      flash_chip_select_n  <= 1'b1;
      flash_read_strobe_n  <= 1'b1;
      flash_write_strobe_n <= 1'b1;
      flash_data_out       <= 16'h0000;
      flash_data_oe        <= 1'b0;
      flash_reset_out_n    <= 1'b0;
    end
    else
    begin
      flash_reset_out_n    <= !soft_rst;
      flash_address[10:1]  <= host_ctl.addr[10:1];
      flash_address[0]     <= lanes.byte_mode && (lanes.en_odd || lanes.odd_on_even);
      flash_byte_mode_n    <= !lanes.byte_mode;
      flash_chip_select_n  <= !common_acc;
      flash_read_strobe_n  <= !(common_acc && !host_ctl.mem_read_strobe_n);
      flash_write_strobe_n <= !(common_acc && !host_ctl.mem_write_strobe_n);
      flash_data_oe        <= common_acc && !host_ctl.mem_write_strobe_n;
      flash_data_out       <= lanes.byte_mode ? {8'h00, wr_byte} : host_data_in;
    end
  end

  // processor reads of the three registers
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      proc_data_out <= 8'h00;
    else
      proc_data_out <= io_select(proc_ctl.addr, io_addr_reg, io_data_reg, io_stat);
  end
  assign proc_data_oe = !proc_ctl.space_select_n && !proc_ctl.read_strobe_n;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  ack_timing_a: assert property (io_mode && attr_acc && !host_ctl.io_read_strobe_n |-> !io_read_ack_n)
    else $error("read ack missing on i/o read");
  mem_ready_a: assert property (!io_mode && !flash_ready_in_n && !$changed(cfg_opt) |=> !ready_or_irq_out)
    else $error("ready pin not busy with flash busy");
  soft_reset_a: assert property (!io_mode && soft_rst ##1 !io_mode |-> !ready_or_irq_out)
    else $error("ready pin high during soft reset");
  irq_set_a: assert property (io_mode && proc_wr_fall && proc_ctl.addr == csb_pkg::IO_DATA_REG
                              ##1 io_mode |=> !ready_or_irq_out)
    else $error("interrupt not raised after processor write");
  mem_status_a: assert property (!io_mode && !$past(io_mode) |-> status_change_out_n)
    else $error("status change low in memory mode");
  extend_proc_a: assert property (io_acc && !proc_ctl.space_select_n |-> !cycle_extend_n)
    else $error("host cycle not extended for processor");
  extend_flash_a: assert property (common_acc && !flash_wait_in_n |-> !cycle_extend_n)
    else $error("flash wait not passed to host");
  byte_addr_a: assert property (lanes.byte_mode && lanes.en_odd && card_sel |=> flash_address[0] && !flash_byte_mode_n)
    else $error("odd byte not steered to flash high byte");
  lanes_off_a: assert property (!card_sel |-> !host_even_oe && !host_odd_oe)
    else $error("host lanes driven with no select");
  write_cis_a: assert property (mem_wr_fall && attr_acc && host_ctl.addr < 11'h010 |=> $stable(cfg_opt))
    else $error("info table write changed a register");

  io_read_c: cover property (io_mode && io_rd_rise && attr_acc);
  proc_irq_c: cover property (proc_wr_fall ##[1:16] io_rd_rise);
  flash_word_c: cover property (common_acc && !lanes.byte_mode && !host_ctl.mem_write_strobe_n);
  status_chg_c: cover property (io_mode && !status_change_out_n);
endmodule // csb_card_ctrl

/* verif/csb_host_model.sv */
// host bus adapter model that drives the card slot pins
`timescale 1ns/100ps
module csb_host_model (
  input  wire logic              ref_clk,
  output csb_pkg::csb_host_ctl_t host_ctl,
  output logic [15:0]            host_data_in
);
  initial
  begin
    host_ctl     = '1;
    host_data_in = 16'h0000;
  end

  // kind 0 memory read, 1 memory write, 2 i/o read, 3 i/o write; strobe stays low until stop
  task automatic start(input logic [1:0] kind, input logic [10:0] a, input logic sp,
                       input logic ev, input logic od, input logic [15:0] d);
    host_ctl.addr               <= a;
    host_ctl.space_select       <= sp;
    host_ctl.even_lane_select_n <= ev;
    host_ctl.odd_lane_select_n  <= od;
    host_data_in                <= d;
    host_ctl.mem_read_strobe_n  <= (kind != 2'h0);
    host_ctl.mem_write_strobe_n <= (kind != 2'h1);
    host_ctl.io_read_strobe_n   <= (kind != 2'h2);
    host_ctl.io_write_strobe_n  <= (kind != 2'h3);
    @(posedge ref_clk);
  endtask

  // released data lines flip so a stale value can never pass for fresh data
  task automatic stop();
    host_ctl     <= '1;
    host_data_in <= ~host_data_in;
    @(posedge ref_clk);
  endtask
endmodule // csb_host_model

/* verif/card_slot_bridge_controller_tb_top.sv */
// self-checking bench for the card slot controller
`timescale 1ns/100ps
module card_slot_bridge_controller_tb_top;
  typedef struct {string name; logic [1:0] sel; logic [15:0] mask; logic [15:0] exp;} csb_note_t;
  logic                   ref_clk = 1'b0;
  logic                   reset = 1'b1;
  logic                   processor_clock = 1'b0;
  csb_pkg::csb_host_ctl_t host_ctl;
  csb_pkg::csb_proc_ctl_t proc_ctl;
  logic [15:0]            host_data_in, host_data_out, flash_data_in, flash_data_out, fword, pins, seen;
  logic [10:0]            flash_address, a;
  logic [7:0]             proc_data_in, proc_data_out, pb;
  logic                   host_even_oe, host_odd_oe, io_read_ack_n, ready_or_irq_out, status_change_out_n;
  logic                   cycle_extend_n, flash_ready_in_n, flash_wait_in_n, flash_byte_mode_n;
  logic                   flash_reset_out_n, flash_read_strobe_n, flash_chip_select_n;
  logic                   flash_write_strobe_n, flash_data_oe, proc_data_oe;
  logic [31:0]            rnd = 32'h4EFCE8A8;
  int                     fails = 0;
  int                     total_checks = 0;
  int                     cycles = 0;
  csb_note_t              notes[$];
  csb_note_t              n;

  always #20 ref_clk = ~ref_clk;
  always
  begin
    #6.2 processor_clock = 1'b1;
    #6.3 processor_clock = 1'b0;
  end

  // flash model: outside a read the bus shows the inverse word
  assign flash_data_in = flash_read_strobe_n ? ~fword : fword;
  assign pins = {2'b00, flash_write_strobe_n, flash_data_oe, flash_chip_select_n, flash_read_strobe_n,
                 flash_reset_out_n, ready_or_irq_out, status_change_out_n, io_read_ack_n, cycle_extend_n,
                 host_even_oe, host_odd_oe, flash_byte_mode_n, proc_data_oe, 1'b0};

  csb_host_model u_host (.ref_clk(ref_clk), .host_ctl(host_ctl), .host_data_in(host_data_in));

  csb_card_ctrl #(.CIS_DEPTH(16)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .host_ctl(host_ctl), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_even_oe(host_even_oe), .host_odd_oe(host_odd_oe),
    .io_read_ack_n(io_read_ack_n), .ready_or_irq_out(ready_or_irq_out),
    .status_change_out_n(status_change_out_n), .cycle_extend_n(cycle_extend_n),
    .flash_ready_in_n(flash_ready_in_n), .flash_wait_in_n(flash_wait_in_n),
    .flash_byte_mode_n(flash_byte_mode_n), .flash_address(flash_address),
    .flash_reset_out_n(flash_reset_out_n), .flash_read_strobe_n(flash_read_strobe_n),
    .flash_chip_select_n(flash_chip_select_n), .flash_write_strobe_n(flash_write_strobe_n),
    .flash_data_in(flash_data_in), .flash_data_out(flash_data_out), .flash_data_oe(flash_data_oe),
    .processor_clock(processor_clock), .proc_ctl(proc_ctl), .proc_data_in(proc_data_in),
    .proc_data_out(proc_data_out), .proc_data_oe(proc_data_oe));

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // sel 0 host data, 1 pin vector, 2 flash low byte over processor data, 3 flash address
  task automatic exp_note(input string name, input logic [1:0] sel, input logic [15:0] m, input logic [15:0] e);
    notes.push_back('{name, sel, m, e});
    @(posedge ref_clk);
  endtask

  task automatic wr_attr(input logic [10:0] ad, input logic [7:0] d);
    u_host.start(2'h1, ad, 1'b0, 1'b0, 1'b1, {8'h00, d});
    u_host.stop();
  endtask

  task automatic rd_attr(input string name, input logic [10:0] ad, input logic [15:0] m, input logic [15:0] e);
    u_host.start(2'h0, ad, 1'b0, 1'b0, 1'b1, 16'h0000);
    repeat (2) @(posedge ref_clk);
    exp_note(name, 2'h0, m, e);
    u_host.stop();
  endtask

  task automatic proc_go(input logic wr, input logic [1:0] ad, input logic [7:0] d);
    proc_ctl     <= {ad, 1'b0, wr, ~wr};
    proc_data_in <= d;
    @(posedge ref_clk);
  endtask

  // watcher: one note taken per cycle, on settled outputs
  always @(negedge ref_clk)
    if (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.sel)
        2'h0: seen = host_data_out;
        2'h1: seen = pins;
        2'h2: seen = {flash_data_out[7:0], proc_data_out};
        default: seen = {5'h00, flash_address};
      endcase
      check(n.name, seen & n.mask, n.exp);
    end

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    proc_ctl         = '1;
    proc_data_in     = 8'h00;
    flash_ready_in_n = 1'b1;
    flash_wait_in_n  = 1'b1;
    fword            = 16'h0000;
    repeat (11) @(posedge ref_clk);
    exp_note("reset pins", 2'h1, 16'h0380, 16'h0080);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    exp_note("ready after reset", 2'h1, 16'h0380, 16'h0380);
    flash_ready_in_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    exp_note("flash busy", 2'h1, 16'h0180, 16'h0080);
    flash_ready_in_n <= 1'b1;
    wr_attr(csb_pkg::CFG_OPT_ADDR, 8'h80);
    @(posedge ref_clk);
    exp_note("soft reset", 2'h1, 16'h0300, 16'h0000);
    wr_attr(csb_pkg::CFG_OPT_ADDR, 8'h00);
    repeat (3) @(posedge ref_clk);
    exp_note("soft reset off", 2'h1, 16'h0300, 16'h0300);
    wr_attr(csb_pkg::CFG_STAT_ADDR, 8'h30);
    rd_attr("status reg", csb_pkg::CFG_STAT_ADDR, 16'h00DF, 16'h0010);
    rd_attr("pin ready", csb_pkg::PIN_REP_ADDR, 16'h0002, 16'h0002);
    // lane table: even byte, odd byte on even lane, odd alone, full word
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr_step(rnd);
      fword <= rnd[15:0];
      a = {rnd[26:17], i == 1};
      flash_wait_in_n <= i[0];
      u_host.start(2'h0, a, 1'b1, i == 2, i < 2, 16'h0000);
      repeat (2) @(posedge ref_clk);
      exp_note("flash pins", 2'h1, 16'h0C3C, {10'h000, i[0], i != 2, i >= 2, i == 3, 2'b00});
      exp_note("flash addr", 2'h3, 16'h07FF, {5'h00, a[10:1], (i == 1) | (i == 2)});
      if (i < 2)
        exp_note("even lane", 2'h0, 16'h00FF, {8'h00, fword[7:0]});
      else if (i == 2)
        exp_note("odd lane", 2'h0, 16'hFF00, {fword[7:0], 8'h00});
      else
        exp_note("word", 2'h0, 16'hFFFF, fword);
      u_host.stop();
    end
    flash_wait_in_n <= 1'b1;
    // odd byte alone written to flash: strobe, data enable, byte on flash low lane
    rnd = lfsr_step(rnd);
    u_host.start(2'h1, rnd[10:0], 1'b1, 1'b1, 1'b0, rnd[31:16]);
    @(posedge ref_clk);
    exp_note("flash write pins", 2'h1, 16'h3C04, 16'h1400);
    exp_note("flash write byte", 2'h2, 16'hFF00, {rnd[31:24], 8'h00});
    u_host.stop();
    wr_attr(csb_pkg::CFG_OPT_ADDR, 8'h01);
    wr_attr(csb_pkg::CFG_STAT_ADDR, 8'h30);
    wr_attr(11'h000, 8'hFF);
    rd_attr("info write", csb_pkg::CFG_OPT_ADDR, 16'h00FF, 16'h0001);
    rnd = lfsr_step(rnd);
    pb = rnd[7:0];
    proc_go(1'b1, csb_pkg::IO_DATA_REG, pb);
    proc_ctl     <= '1;
    proc_data_in <= ~pb;
    repeat (3) @(posedge ref_clk);
    exp_note("irq set", 2'h1, 16'h0100, 16'h0000);
    proc_ctl.space_select_n <= 1'b0;
    u_host.start(2'h2, {9'h000, csb_pkg::IO_DATA_REG}, 1'b0, 1'b0, 1'b1, 16'h0000);
    @(posedge ref_clk);
    exp_note("io read pins", 2'h1, 16'h0070, 16'h0010);
    exp_note("io read data", 2'h0, 16'h00FF, {8'h00, pb});
    u_host.stop();
    proc_ctl <= '1;
    repeat (2) @(posedge ref_clk);
    exp_note("irq clear", 2'h1, 16'h0100, 16'h0100);
    u_host.start(2'h3, {9'h000, csb_pkg::IO_ADDR_REG}, 1'b0, 1'b0, 1'b1, {8'h00, ~pb});
    u_host.stop();
    repeat (3) @(posedge ref_clk);
    proc_go(1'b0, csb_pkg::IO_ADDR_REG, 8'h00);
    @(posedge ref_clk);
    exp_note("proc read", 2'h2, 16'h00FF, {8'h00, ~pb});
    exp_note("proc oe", 2'h1, 16'h0002, 16'h0002);
    proc_ctl <= '1;
    flash_ready_in_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    exp_note("ready change", 2'h1, 16'h0180, 16'h0100);
    flash_ready_in_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    results();
  end
endmodule // card_slot_bridge_controller_tb_top
